// ===== rtl/sysctl_pkg.sv
// Purpose: Constants and types for the system wakeup, low-voltage and
//          pending-interrupt register bank.
// Assumes: 100 MHz bus clock, APB with 32-bit data, 1 ms wakeup tick.
// Notes:   Summary list below; byte offsets are word aligned.
//
// Summary of operation
// - Wakeup control bit 4 enables wakeup timeout interrupt requests.
// - Wakeup control bits 2:0 select period; code 000 disables the timer.
// - Codes 001..111 give 8,32,64,128,256,512 ms and 1.024 s at 1 ms.
// - 1-kHz oscillator powers down in stop only with period 000, select 1.
// - Low-voltage flag, power bit 7, sets on detect event while enabled.
// - Writing 1 to power bit 6 clears low-voltage flag; reads 0.
// - Power bit 5 set: interrupt requested while low-voltage flag and detect enable are 1.
// - Reset forced when flag, reset enable bit 4 and detect enable set.
// - Power bit 3 keeps detection alive in stop, only with detect enable.
// - Write-once power bit 2 enables detection and qualifies other bits.
// - Write-once power bits accept only first write after reset.
// - Power bit 0 drives the bandgap buffer enable output.
// - Pending bit 4 is keypad flag AND keypad interrupt enable.
// - Pending bit 3 is comparator flag AND comparator interrupt enable.
// - Pending bit 2 is timer overflow flag AND its interrupt enable.
// - Pending bit 1 is wakeup timeout flag AND wakeup interrupt enable.
// - Pending bit 0 is low-voltage flag AND interrupt enable AND enable.
// - Wakeup flag bit 7 sets on expiry; writing 1 to bit 6 clears it.
// - Wakeup control bit 5 picks 1-kHz oscillator or 32-kHz divided by 32.
package sysctl_pkg;

  localparam int unsigned ADDR_W = 12;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] WAKEUP_CTRL_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] POWER_CTRL_OFS  = 12'h004;
  localparam logic [ADDR_W-1:0] PENDING_OFS     = 12'h008;

  // Wakeup control fields
  localparam int unsigned WK_FLAG_BIT   = 7;
  localparam int unsigned WK_CLEAR_BIT  = 6;
  localparam int unsigned WK_CLKSEL_BIT = 5;
  localparam int unsigned WK_IRQEN_BIT  = 4;
  localparam int unsigned WK_PERIOD_LSB = 0;
  localparam int unsigned WK_PERIOD_W   = 3;

  // Power management fields
  localparam int unsigned LV_FLAG_BIT   = 7;
  localparam int unsigned LV_CLEAR_BIT  = 6;
  localparam int unsigned LV_IRQEN_BIT  = 5;
  localparam int unsigned LV_RSTEN_BIT  = 4;
  localparam int unsigned LV_STOPEN_BIT = 3;
  localparam int unsigned LV_DETEN_BIT  = 2;
  localparam int unsigned LV_BANDGAP_BUFFER_ENABLE_BIT   = 0;

  // Pending register fields
  localparam int unsigned PEND_KEYPAD_BIT = 4;
  localparam int unsigned PEND_COMP_BIT   = 3;
  localparam int unsigned PEND_TIMER_BIT  = 2;
  localparam int unsigned PEND_WAKEUP_BIT = 1;
  localparam int unsigned PEND_LV_BIT     = 0;

  // Reset values
  localparam logic [WK_PERIOD_W-1:0] WK_PERIOD_RST = 3'h0;
  localparam logic WK_IRQEN_RST  = 1'b0;
  localparam logic WK_CLKSEL_RST = 1'b0;
  localparam logic LV_IRQEN_RST  = 1'b0;
  localparam logic LV_RSTEN_RST  = 1'b1;
  localparam logic LV_STOPEN_RST = 1'b1;
  localparam logic LV_DETEN_RST  = 1'b1;
  localparam logic LV_BANDGAP_BUFFER_ENABLE_RST   = 1'b0;

  // Timing
  localparam int unsigned TICK_MS        = 1;
  localparam int unsigned SLOW_DIV       = 32;
  localparam int unsigned SLOW_DIV_W     = 5;
  localparam int unsigned WK_COUNT_W     = 11;
  localparam logic [WK_PERIOD_W-1:0] WK_PERIOD_OFF = 3'h0;

  typedef logic [WK_COUNT_W-1:0] wk_count_t;

  // Timeout in 1 ms ticks for each period code
  function automatic wk_count_t period_ticks(
    input logic [WK_PERIOD_W-1:0] code);
    case (code)
      3'h1:    period_ticks = 11'h008 / wk_count_t'(TICK_MS);
      3'h2:    period_ticks = 11'h020 / wk_count_t'(TICK_MS);
      3'h3:    period_ticks = 11'h040 / wk_count_t'(TICK_MS);
      3'h4:    period_ticks = 11'h080 / wk_count_t'(TICK_MS);
      3'h5:    period_ticks = 11'h100 / wk_count_t'(TICK_MS);
      3'h6:    period_ticks = 11'h200 / wk_count_t'(TICK_MS);
      3'h7:    period_ticks = 11'h400 / wk_count_t'(TICK_MS);
      default: period_ticks = 11'h000;
    endcase
  endfunction : period_ticks

  // Flags and enables from neighbouring peripherals
  typedef struct packed {
    logic keypad_flag;
    logic keypad_irq_enable;
    logic comparator_flag;
    logic comparator_irq_enable;
    logic timer_overflow_flag;
    logic timer_overflow_irq_enable;
  } irq_sources_t;

  // Requests and controls driven toward the rest of the chip
  typedef struct packed {
    logic wakeup_irq;
    logic low_voltage_irq;
    logic low_voltage_reset;
    logic bandgap_buffer_enable;
    logic osc_1khz_power_down;
    logic low_voltage_detect_active;
  } sys_requests_t;

endpackage : sysctl_pkg

// ===== rtl/system_wakeup_lvd_pending_regs.sv
// Purpose: APB register bank for the periodic wakeup timer, low-voltage
//          detect control and the interrupt pending summary.
// Assumes: Single 100 MHz clock, synchronous active-high reset; wakeup
//          clock and detector inputs are asynchronous pins.
// Notes:   Zero-wait APB slave; read data captured in the setup cycle.
//
// Local design decisions: the address map and the APB register port.
`timescale 1ns/1ps
module system_wakeup_lvd_pending_regs
  import sysctl_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                sys_rst,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                osc_1khz_clk,
  input  wire logic                osc_32khz_clk,
  input  wire logic                low_voltage_event,
  input  wire logic                stop_mode,
  input  wire irq_sources_t        irq_sources,
  output sys_requests_t            sys_requests
);

  // Pin synchronisers: first stage read only by second stage
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic [2:0] pin_s;
  logic [2:0] pin_prev;

  // Registers
  logic [WK_PERIOD_W-1:0] wakeup_period_select;
  logic                   wakeup_irq_enable;
  logic                   wakeup_clock_select;
  logic                   wakeup_timeout_flag;
  logic                   low_voltage_flag;
  logic                   low_voltage_irq_enable;
  logic                   low_voltage_reset_enable;
  logic                   low_voltage_stop_enable;
  logic                   low_voltage_detect_enable;
  logic                   bandgap_buffer_enable;
  logic                   write_once_locked;

  // Wakeup timer
  logic [SLOW_DIV_W-1:0]  slow_div;
  wk_count_t              wk_count;
  logic                   slow_tick;
  logic                   ms_tick;
  logic                   wk_expire;
  logic                   wk_running;

  // Bus decode
  logic                   setup_phase;
  logic                   wr_access;
  logic                   wr_wakeup;
  logic                   wr_power;
  logic                   lv_detect_live;
  logic                   lv_set;
  logic [7:0]             pending;
  logic [31:0]            next_prdata;
  logic                   next_pslverr;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sync_a   <= 3'h0;
      sync_b   <= 3'h0;
      pin_prev <= 3'h0;
    end else begin
      sync_a   <= {low_voltage_event, osc_32khz_clk, osc_1khz_clk};
      sync_b   <= sync_a;
      pin_prev <= sync_b;
    end
  end

  assign pin_s = sync_b;

  // Bus strobes
  assign setup_phase = psel && !penable;
  assign wr_access   = psel && penable && pwrite;
  assign wr_wakeup   = wr_access && (paddr == WAKEUP_CTRL_OFS);
  assign wr_power    = wr_access && (paddr == POWER_CTRL_OFS);
  assign pready      = psel && penable;

  // Wakeup control register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wakeup_period_select <= WK_PERIOD_RST;
      wakeup_irq_enable    <= WK_IRQEN_RST;
      wakeup_clock_select  <= WK_CLKSEL_RST;
    end else if (wr_wakeup) begin
      wakeup_period_select <=
        pwdata[WK_PERIOD_LSB +: WK_PERIOD_W];
      wakeup_irq_enable    <= pwdata[WK_IRQEN_BIT];
      wakeup_clock_select  <= pwdata[WK_CLKSEL_BIT];
    end
  end

  // Clock source: rising edge of 1-kHz pin, or 32-kHz pin divided by 32
  assign slow_tick = pin_s[1] && !pin_prev[1];

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      slow_div <= '0;
    end else if (slow_tick) begin
      slow_div <= slow_div + SLOW_DIV_W'(1);
    end
  end

  always_comb begin
    if (wakeup_clock_select) begin
      ms_tick = slow_tick &&
        (slow_div == SLOW_DIV_W'(SLOW_DIV - 1));
    end else begin
      ms_tick = pin_s[0] && !pin_prev[0];
    end
  end

  assign wk_running = wakeup_period_select != WK_PERIOD_OFF;
  assign wk_expire  = wk_running && ms_tick &&
    (wk_count == period_ticks(wakeup_period_select) - 11'h001);

  // Timeout counter restarts on any write to the period or source
  always_ff @(posedge clock) begin
    if (sys_rst || !wk_running || wr_wakeup) begin
      wk_count <= '0;
    end else if (wk_expire) begin
      wk_count <= '0;
    end else if (ms_tick) begin
      wk_count <= wk_count + 11'h001;
    end
  end

  // Timeout flag: a new expiry wins over a simultaneous clear
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      wakeup_timeout_flag <= 1'b0;
    end else if (wk_expire) begin
      wakeup_timeout_flag <= 1'b1;
    end else if (wr_wakeup && pwdata[WK_CLEAR_BIT]) begin
      wakeup_timeout_flag <= 1'b0;
    end
  end

  // Power management register; write-once bits lock on first write
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      low_voltage_irq_enable    <= LV_IRQEN_RST;
      low_voltage_stop_enable   <= LV_STOPEN_RST;
      bandgap_buffer_enable     <= LV_BANDGAP_BUFFER_ENABLE_RST;
      low_voltage_reset_enable  <= LV_RSTEN_RST;
      low_voltage_detect_enable <= LV_DETEN_RST;
      write_once_locked         <= 1'b0;
    end else if (wr_power) begin
      low_voltage_irq_enable  <= pwdata[LV_IRQEN_BIT];
      low_voltage_stop_enable <= pwdata[LV_STOPEN_BIT];
      bandgap_buffer_enable   <= pwdata[LV_BANDGAP_BUFFER_ENABLE_BIT];
      write_once_locked       <= 1'b1;
      if (!write_once_locked) begin
        low_voltage_reset_enable  <= pwdata[LV_RSTEN_BIT];
        low_voltage_detect_enable <= pwdata[LV_DETEN_BIT];
      end
    end
  end

  // Detector is sampled only when enabled, and in stop only if allowed
  assign lv_detect_live = low_voltage_detect_enable &&
    (!stop_mode || low_voltage_stop_enable);
  assign lv_set = lv_detect_live && pin_s[2];

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      low_voltage_flag <= 1'b0;
    end else if (lv_set) begin
      low_voltage_flag <= 1'b1;
    end else if (wr_power && pwdata[LV_CLEAR_BIT]) begin
      low_voltage_flag <= 1'b0;
    end
  end

  // Pending summary, live from sources
  always_comb begin
    pending = 8'h00;
    pending[PEND_KEYPAD_BIT] = irq_sources.keypad_flag &&
      irq_sources.keypad_irq_enable;
    pending[PEND_COMP_BIT]   = irq_sources.comparator_flag &&
      irq_sources.comparator_irq_enable;
    pending[PEND_TIMER_BIT]  = irq_sources.timer_overflow_flag &&
      irq_sources.timer_overflow_irq_enable;
    pending[PEND_WAKEUP_BIT] = wakeup_timeout_flag &&
      wakeup_irq_enable;
    pending[PEND_LV_BIT]     = low_voltage_flag &&
      low_voltage_irq_enable &&
      low_voltage_detect_enable;
  end

  // Read mux; clear bits always read as zero
  always_comb begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    case (paddr)
      WAKEUP_CTRL_OFS: begin
        next_prdata[WK_FLAG_BIT]   = wakeup_timeout_flag;
        next_prdata[WK_CLKSEL_BIT] = wakeup_clock_select;
        next_prdata[WK_IRQEN_BIT]  = wakeup_irq_enable;
        next_prdata[WK_PERIOD_LSB +: WK_PERIOD_W] = wakeup_period_select;
      end
      POWER_CTRL_OFS: begin
        next_prdata[LV_FLAG_BIT]   = low_voltage_flag;
        next_prdata[LV_IRQEN_BIT]  = low_voltage_irq_enable;
        next_prdata[LV_RSTEN_BIT]  = low_voltage_reset_enable;
        next_prdata[LV_STOPEN_BIT] = low_voltage_stop_enable;
        next_prdata[LV_DETEN_BIT]  = low_voltage_detect_enable;
        next_prdata[LV_BANDGAP_BUFFER_ENABLE_BIT]   = bandgap_buffer_enable;
      end
      PENDING_OFS: begin
        next_prdata[7:0] = pending;
      end
      default: begin
        next_pslverr = 1'b1;
      end
    endcase
  end

  // Read data and error captured in the setup cycle
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // Requests toward the chip
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sys_requests <= '0;
    end else begin
      sys_requests.wakeup_irq <= pending[PEND_WAKEUP_BIT];
      sys_requests.low_voltage_irq <= pending[PEND_LV_BIT];
      sys_requests.low_voltage_reset <= low_voltage_flag &&
        low_voltage_reset_enable &&
        low_voltage_detect_enable;
      sys_requests.bandgap_buffer_enable <= bandgap_buffer_enable;
      sys_requests.osc_1khz_power_down <= stop_mode &&
        !wk_running && wakeup_clock_select;
      sys_requests.low_voltage_detect_active <= lv_detect_live;
    end
  end

endmodule : system_wakeup_lvd_pending_regs

// ===== testbench/sysctl_checker_assertions.sv
// Purpose: Port checks for the wakeup, low-voltage and pending bank.
// Assumes: Zero-wait APB; request outputs one cycle behind causes.
// Notes:   Reads tie captured fields to the request outputs.
`timescale 1ns/1ps
module sysctl_checker
  import sysctl_pkg::*;
(
  input wire logic                clock,
  input wire logic                sys_rst,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [ADDR_W-1:0]   paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic                osc_1khz_clk,
  input wire logic                osc_32khz_clk,
  input wire logic                low_voltage_event,
  input wire logic                stop_mode,
  input wire irq_sources_t        irq_sources,
  input wire sys_requests_t       sys_requests
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic rd_p;
  logic rd_w;
  logic rd_v;
  assign rd_p = psel && penable && !pwrite && paddr == PENDING_OFS;
  assign rd_w = psel && penable && !pwrite && paddr == WAKEUP_CTRL_OFS;
  assign rd_v = psel && penable && !pwrite && paddr == POWER_CTRL_OFS;

  a_keypad_pend: assert property (rd_p |-> prdata[4] ==
    $past(irq_sources.keypad_flag && irq_sources.keypad_irq_enable))
    else $error("keypad pending wrong");
  a_comp_pend: assert property (rd_p |-> prdata[3] ==
    $past(irq_sources.comparator_flag && irq_sources.comparator_irq_enable))
    else $error("comparator pending wrong");
  a_timer_pend: assert property (rd_p |-> prdata[2] == $past(
    irq_sources.timer_overflow_flag && irq_sources.timer_overflow_irq_enable))
    else $error("timer pending wrong");
  a_wakeup_pend: assert property (rd_p |-> prdata[1:0] ==
    {sys_requests.wakeup_irq, sys_requests.low_voltage_irq})
    else $error("wakeup or low-voltage pending wrong");
  a_wakeup_irq: assert property (rd_w |-> !prdata[6] &&
    sys_requests.wakeup_irq == (prdata[7] && prdata[4]))
    else $error("wakeup request wrong");
  a_osc_power_down: assert property (rd_w |->
    sys_requests.osc_1khz_power_down ==
    ($past(stop_mode) && prdata[2:0] == 3'h0 && prdata[5]))
    else $error("oscillator power down wrong");
  a_lv_irq_read: assert property (rd_v |-> !prdata[6] &&
    sys_requests.low_voltage_irq == (prdata[7] && prdata[5] && prdata[2]))
    else $error("low-voltage request wrong");
  a_lv_reset_read: assert property (rd_v |->
    sys_requests.low_voltage_reset == (prdata[7] && prdata[4] && prdata[2]))
    else $error("low-voltage reset wrong");
  a_lv_detect_live: assert property (rd_v |->
    sys_requests.low_voltage_detect_active ==
    (prdata[2] && (!$past(stop_mode) || prdata[3])))
    else $error("detect activity wrong");
  a_bandgap_follow: assert property (psel && penable && pwrite &&
    paddr == POWER_CTRL_OFS |-> ##2
    sys_requests.bandgap_buffer_enable == $past(pwdata[0], 2))
    else $error("bandgap enable wrong");
endmodule : sysctl_checker

bind system_wakeup_lvd_pending_regs sysctl_checker i_sysctl_checker (
  .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .osc_1khz_clk(osc_1khz_clk),
  .osc_32khz_clk(osc_32khz_clk), .low_voltage_event(low_voltage_event),
  .stop_mode(stop_mode), .irq_sources(irq_sources),
  .sys_requests(sys_requests));

// ===== testbench/test_system_wakeup_lvd_pending_regs.sv
// Purpose: Directed bench for the wakeup, low-voltage and pending bank.
// Assumes: Zero-wait APB slave; slow pin clocks toggled by the bench.
// Notes:   Each scenario task judges its own results.
`timescale 1ns/1ps
module test_system_wakeup_lvd_pending_regs;
  import sysctl_pkg::*;
  logic                clock;
  logic                sys_rst;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [ADDR_W-1:0]   paddr;
  logic [31:0]         pwdata;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic                osc_1khz_clk;
  logic                osc_32khz_clk;
  logic                low_voltage_event;
  logic                stop_mode;
  irq_sources_t        irq_sources;
  sys_requests_t       sys_requests;
  logic                last_err;
  int                  mismatches;
  int                  cmp_count;

  system_wakeup_lvd_pending_regs i_system_wakeup_lvd_pending_regs (
    .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .osc_1khz_clk(osc_1khz_clk),
    .osc_32khz_clk(osc_32khz_clk), .low_voltage_event(low_voltage_event),
    .stop_mode(stop_mode), .irq_sources(irq_sources),
    .sys_requests(sys_requests));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic conclude();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [7:0] wd, output logic [31:0] rd);
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, wd};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    rd = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, r);
  endtask : wr

  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [31:0] e,
                       input string nm);
    logic [31:0] r;
    apb(1'b0, a, 8'h00, r);
    chk(nm, e, r);
  endtask : rdchk

  task automatic reset();
    sys_rst <= 1'b1;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
  endtask : reset

  // Slow pin clock edges, each level held four bus cycles
  task automatic ticks(input logic fast, input int n);
    repeat (n) begin
      if (fast) osc_32khz_clk <= 1'b1;
      else osc_1khz_clk <= 1'b1;
      repeat (4) @(posedge clock);
      osc_32khz_clk <= 1'b0;
      osc_1khz_clk  <= 1'b0;
      repeat (4) @(posedge clock);
    end
  endtask : ticks

  task automatic lv_pulse();
    low_voltage_event <= 1'b1;
    repeat (6) @(posedge clock);
    low_voltage_event <= 1'b0;
    repeat (5) @(posedge clock);
  endtask : lv_pulse

  task automatic t_reset();
    rdchk(WAKEUP_CTRL_OFS, 32'h00, "wk_reset");
    rdchk(POWER_CTRL_OFS, 32'h1C, "pw_reset");
    rdchk(PENDING_OFS, 32'h00, "pend_reset");
    rdchk(12'h00C, 32'h00, "unmapped");
    chk("slverr", 32'h1, {31'h0, last_err});
  endtask : t_reset

  task automatic t_pending();
    logic [31:0] e;
    for (int s = 0; s < 3; s++) begin
      for (int c = 1; c < 4; c++) begin
        irq_sources <= irq_sources_t'(6'(c) << (2 * (2 - s)));
        e = (c == 3) ? (32'h0000_0010 >> s) : 32'h0000_0000;
        rdchk(PENDING_OFS, e, "pend");
      end
    end
    irq_sources <= '0;
  endtask : t_pending

  task automatic t_wakeup();
    wr(WAKEUP_CTRL_OFS, 8'hF7);
    rdchk(WAKEUP_CTRL_OFS, 32'h37, "wk_ctrl");
    wr(WAKEUP_CTRL_OFS, 8'h00);
    ticks(1'b0, 10);
    rdchk(WAKEUP_CTRL_OFS, 32'h00, "wk_off");
    wr(WAKEUP_CTRL_OFS, 8'h11);
    ticks(1'b0, 6);
    rdchk(WAKEUP_CTRL_OFS, 32'h11, "wk_early");
    ticks(1'b0, 4);
    rdchk(WAKEUP_CTRL_OFS, 32'h91, "wk_expired");
    rdchk(PENDING_OFS, 32'h02, "wk_pend");
    wr(WAKEUP_CTRL_OFS, 8'h61);
    rdchk(WAKEUP_CTRL_OFS, 32'h21, "wk_cleared");
    ticks(1'b1, 192);
    rdchk(WAKEUP_CTRL_OFS, 32'h21, "wk_slow_early");
    ticks(1'b1, 128);
    rdchk(WAKEUP_CTRL_OFS, 32'hA1, "wk_slow_exp");
    rdchk(PENDING_OFS, 32'h00, "wk_masked");
    stop_mode <= 1'b1;
    wr(WAKEUP_CTRL_OFS, 8'h20);
    repeat (2) @(posedge clock);
    chk("osc_pd", 32'h1, {31'h0, sys_requests.osc_1khz_power_down});
    wr(WAKEUP_CTRL_OFS, 8'h21);
    repeat (2) @(posedge clock);
    chk("osc_run", 32'h0, {31'h0, sys_requests.osc_1khz_power_down});
    stop_mode <= 1'b0;
  endtask : t_wakeup

  task automatic t_power();
    wr(POWER_CTRL_OFS, 8'h25);
    rdchk(POWER_CTRL_OFS, 32'h25, "pw_first");
    wr(POWER_CTRL_OFS, 8'h19);
    rdchk(POWER_CTRL_OFS, 32'h0D, "pw_locked");
    wr(POWER_CTRL_OFS, 8'h24);
    stop_mode <= 1'b1;
    lv_pulse();
    rdchk(POWER_CTRL_OFS, 32'h24, "lv_stopped");
    stop_mode <= 1'b0;
    lv_pulse();
    rdchk(POWER_CTRL_OFS, 32'hA4, "lv_flag");
    rdchk(PENDING_OFS, 32'h01, "lv_pend");
    chk("lv_irq", 32'h1, {31'h0, sys_requests.low_voltage_irq});
    wr(POWER_CTRL_OFS, 8'h64);
    rdchk(POWER_CTRL_OFS, 32'h24, "lv_cleared");
    reset();
    lv_pulse();
    chk("lv_rst", 32'h1, {31'h0, sys_requests.low_voltage_reset});
    rdchk(PENDING_OFS, 32'h00, "lv_polled");
    wr(POWER_CTRL_OFS, 8'h40);
    lv_pulse();
    rdchk(POWER_CTRL_OFS, 32'h00, "lv_off");
  endtask : t_power

  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    osc_1khz_clk = 1'b0;
    osc_32khz_clk = 1'b0;
    low_voltage_event = 1'b0;
    stop_mode = 1'b0;
    irq_sources = '0;
    mismatches = 0;
    cmp_count = 0;
    reset();
    t_reset();
    t_pending();
    t_wakeup();
    t_power();
    conclude();
  end

  initial begin
    repeat (40000) @(posedge clock);
    mismatches++;
    conclude();
  end
endmodule : test_system_wakeup_lvd_pending_regs
